// [core/ppp_port.sv]
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Select out is inverse of control bit 3
// - Initialise out follows control bit 2 directly
// - Auto line feed is inverse of bit 1
// - Data latch pulse is inverse of bit 0
// - Status bit 7 is inverted busy input
// - Status bit 6 reads acknowledge input directly
// - Status bit 5 reads paper-out input directly
// - Status bit 4 reads online input directly
// - Status bit 3 reads fault input directly
// - Port yields pins when floppy routed there
// - Pins take other roles in ECP/EPP
module ppp_port (
    input wire logic I_REF_CLK, // 125 MHz clock.
    input wire logic I_RST, // Asynchronous reset, active high.
    input wire logic I_CE, // Clock enable; state frozen while low.
    input wire logic I_HSEL, // AHB-Lite slave select.
    input wire logic [31:0] I_HADDR, // AHB-Lite address.
    input wire logic [1:0] I_HTRANS, // AHB-Lite transfer type.
    input wire logic I_HWRITE, // AHB-Lite write flag.
    input wire logic [2:0] I_HSIZE, // AHB-Lite transfer size.
    input wire logic [31:0] I_HWDATA, // AHB-Lite write data.
    input wire logic I_HREADY, // AHB-Lite bus ready.
    output logic [31:0] O_HRDATA, // AHB-Lite read data.
    output logic O_HREADYOUT, // Slave ready, always high.
    output logic O_HRESP, // Always OKAY.
    output logic O_IRQ, // Level interrupt.
    output logic O_PRINTER_SELECT_OUT_N, // Select output pin value.
    output logic O_PRINTER_SELECT_OUT_OE, // Select output enable.
    output logic O_PRINTER_INITIALISE_N, // Initialise output pin value.
    output logic O_PRINTER_INITIALISE_OE, // Initialise output enable.
    output logic O_AUTO_LINE_FEED_N, // Line feed output pin value.
    output logic O_AUTO_LINE_FEED_OE, // Line feed output enable.
    output logic O_DATA_LATCH_PULSE_N, // Strobe output pin value.
    output logic O_DATA_LATCH_PULSE_OE, // Strobe output enable.
    input wire logic I_PRINTER_BUSY, // Busy input pin.
    input wire logic I_PRINTER_ACKNOWLEDGE_N, // Acknowledge input pin.
    input wire logic I_PAPER_OUT, // Paper-out input pin.
    input wire logic I_PRINTER_ONLINE, // Online input pin.
    input wire logic I_PRINTER_FAULT_N, // Fault input pin.
    input wire logic [7:0] I_PORT_DATA, // Port data pins, input side.
    output logic [7:0] O_PORT_DATA, // Port data pins, output side.
    output logic O_PORT_DATA_OE, // Port data output enable.
    output logic O_FLOPPY_ROUTED, // Pins handed to the floppy function.
    output logic [1:0] O_PORT_MODE // Selected port mode for ECP/EPP logic.
);
    ////////////////////////////////////////////////////////////////////////////
    // Number of printer status pins brought in through the synchroniser.
    localparam int NPIN = 5;
    // Slot of each status pin in the synchroniser vectors.
    localparam int SYN_FAULT = 0;
    localparam int SYN_ONLINE = 1;
    localparam int SYN_PAPER = 2;
    localparam int SYN_ACK = 3;
    localparam int SYN_BUSY = 4;

    // Two synchroniser stages for the status pins.
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync1_d;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] sync2_d;
    // Two synchroniser stages for the port data pins.
    logic [7:0] pd1_q;
    logic [7:0] pd1_d;
    logic [7:0] pd2_q;
    logic [7:0] pd2_d;
    // Printer control byte and output data latch.
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic [7:0] dat_q;
    logic [7:0] dat_d;
    // Floppy routing flag and port mode select.
    logic [2:0] mode_q;
    logic [2:0] mode_d;
    // Sticky interrupt status and its enable mask.
    logic [ppp_pkg::EV_W-1:0] ist_q;
    logic [ppp_pkg::EV_W-1:0] ist_d;
    logic [ppp_pkg::EV_W-1:0] ien_q;
    logic [ppp_pkg::EV_W-1:0] ien_d;
    // Synchronised pins one cycle older, for edge detection.
    logic [NPIN-1:0] prev_q;
    logic [NPIN-1:0] prev_d;
    // Registered read data for the data phase.
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // Write pending in the data phase and the address it targets.
    logic wr_q;
    logic wr_d;
    logic [ppp_pkg::ADDR_W-1:0] adr_q;
    logic [ppp_pkg::ADDR_W-1:0] adr_d;
    // Status byte as software reads it.
    logic [7:0] status;
    // Pin ownership and bus decode helpers.
    logic floppy;
    logic std_mode;
    logic pins_owned;
    logic addr_ok;
    logic wr_ev;
    // Event strobes and clear requests, one bit per interrupt source.
    logic [ppp_pkg::EV_W-1:0] ev;
    logic [ppp_pkg::EV_W-1:0] clr;

    // True for a taken NONSEQ or SEQ transfer of any size.
    // SEQ is accepted as well, though single NONSEQ transfers are the
    // expected use; the size field is not checked.
    function automatic logic bus_take(input logic sel, input logic [1:0] tr, input logic rdy);
        bus_take = sel && rdy && (tr == ppp_pkg::HTRANS_NONSEQ || tr == ppp_pkg::HTRANS_SEQ);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin inputs cross from outside through two flops before any logic reads them.
    // Reset drives every stage low, which the edge detectors below allow for.
    always_comb
    begin
        sync1_d = {I_PRINTER_BUSY, I_PRINTER_ACKNOWLEDGE_N, I_PAPER_OUT, I_PRINTER_ONLINE, I_PRINTER_FAULT_N};
        sync2_d = sync1_q;
        pd1_d = I_PORT_DATA;
        pd2_d = pd1_q;
        prev_d = sync2_q;
    end

    // Synchroniser, edge history and data pin flops; frozen while the enable is low.
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            // Nothing from the pins is trusted until two enabled edges have passed.
            sync1_q <= '0;
            sync2_q <= '0;
            pd1_q <= '0;
            pd2_q <= '0;
            prev_q <= '0;
        end
        else if (I_CE)
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            pd1_q <= pd1_d;
            pd2_q <= pd2_d;
            prev_q <= prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status byte assembled from synchronised pins; low bits read as zero.
    // The read shows the pins two edges late; a pulse shorter than a clock
    // may be missed, so acknowledge is best watched through its interrupt.
    always_comb
    begin
        status = 8'h00;
        status[ppp_pkg::STS_BUSY] = ~sync2_q[SYN_BUSY];
        status[ppp_pkg::STS_ACK] = sync2_q[SYN_ACK];
        status[ppp_pkg::STS_PAPER] = sync2_q[SYN_PAPER];
        status[ppp_pkg::STS_ONLINE] = sync2_q[SYN_ONLINE];
        status[ppp_pkg::STS_FAULT] = sync2_q[SYN_FAULT];
    end

    // Events: acknowledge falling edge, fault falling edge, paper-out rising edge.
    // The history flops reset low; both falling-edge inputs idle high, so the
    // first cycles after reset show only rising edges there and raise nothing.
    // A paper-out pin already high at reset does raise one event, which
    // software clears on start-up.
    always_comb
    begin
        ev[ppp_pkg::EV_ACK] = prev_q[SYN_ACK] & ~sync2_q[SYN_ACK];
        ev[ppp_pkg::EV_FAULT] = prev_q[SYN_FAULT] & ~sync2_q[SYN_FAULT];
        ev[ppp_pkg::EV_PAPER] = ~prev_q[SYN_PAPER] & sync2_q[SYN_PAPER];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: address phase captured, write applied in the data phase.
    // Zero wait states, so hreadyout stays high and the response is OKAY.
    // A write is remembered at the end of its address phase and lands at the
    // edge that closes its data phase, when hwdata is on the bus.
    // A read is decoded in its address phase and registered, so hrdata stands
    // for exactly the data phase and falls back to zero afterwards.
    // Register map, in byte addresses: data latch or data pins read back,
    // status, control, mode, interrupt status, interrupt clear and enable.
    // Unmapped reads return zero and unmapped writes are dropped.
    assign addr_ok = bus_take(I_HSEL, I_HTRANS, I_HREADY);
    assign wr_ev = wr_q;

    always_comb
    begin
        wr_d = addr_ok && I_HWRITE;
        adr_d = addr_ok ? I_HADDR[ppp_pkg::ADDR_W-1:0] : adr_q;
        ctl_d = ctl_q;
        dat_d = dat_q;
        mode_d = mode_q;
        ien_d = ien_q;
        clr = '0;
        // Writes to the read-only registers fall to the default and are dropped.
        if (wr_ev)
        begin
            case (adr_q)
                ppp_pkg::ADDR_DATA: dat_d = I_HWDATA[7:0];
                ppp_pkg::ADDR_CONTROL: ctl_d = I_HWDATA[7:0];
                ppp_pkg::ADDR_MODE: mode_d = I_HWDATA[2:0];
                ppp_pkg::ADDR_IRQ_CLR: clr = I_HWDATA[ppp_pkg::EV_W-1:0];
                ppp_pkg::ADDR_IRQ_EN: ien_d = I_HWDATA[ppp_pkg::EV_W-1:0];
                default: clr = '0;
            endcase
        end
        // A new event beats a clear in the same cycle.
        ist_d = (ist_q & ~clr) | ev;
        // Unused high bits of every register read as zero.
        rdata_d = ppp_pkg::WORD_ZERO;
        if (addr_ok && !I_HWRITE)
        begin
            case (I_HADDR[ppp_pkg::ADDR_W-1:0])
                ppp_pkg::ADDR_DATA: rdata_d[7:0] = ctl_q[ppp_pkg::CTL_DIR] ? pd2_q : dat_q;
                ppp_pkg::ADDR_STATUS: rdata_d[7:0] = status;
                ppp_pkg::ADDR_CONTROL: rdata_d[7:0] = ctl_q;
                ppp_pkg::ADDR_MODE: rdata_d[2:0] = mode_q;
                ppp_pkg::ADDR_IRQ_STAT: rdata_d[ppp_pkg::EV_W-1:0] = ist_q;
                ppp_pkg::ADDR_IRQ_EN: rdata_d[ppp_pkg::EV_W-1:0] = ien_q;
                default: rdata_d = ppp_pkg::WORD_ZERO;
            endcase
        end
    end

    // Bus and register flops; a transfer taken while the enable is low is lost.
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            // Control resets with initialise high, so the printer is not held in reset.
            wr_q <= 1'b0;
            adr_q <= '0;
            ctl_q <= ppp_pkg::CTL_RESET;
            dat_q <= ppp_pkg::DATA_RESET;
            mode_q <= ppp_pkg::MODE_RESET;
            ien_q <= '0;
            ist_q <= '0;
            rdata_q <= ppp_pkg::WORD_ZERO;
        end
        else if (I_CE)
        begin
            wr_q <= wr_d;
            adr_q <= adr_d;
            ctl_q <= ctl_d;
            dat_q <= dat_d;
            mode_q <= mode_d;
            ien_q <= ien_d;
            ist_q <= ist_d;
            rdata_q <= rdata_d;
        end
    end

    // Bus response: the slave never stalls and never signals an error.
    assign O_HRDATA = rdata_q;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    // Level interrupt; it falls as soon as software clears or masks the bit.
    assign O_IRQ = |(ist_q & ien_q);

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive. Control outputs are plain register decodes so the printer
    // sees a change one cycle after the write; the strobe width is software's.
    // Nothing here times the strobe against the data, so software must set the
    // data latch first and hold the strobe long enough for the printer.
    // Mode bit 0 routes the floppy function; the two bits above pick the mode.
    assign floppy = mode_q[ppp_pkg::MODE_FLOPPY];
    assign O_PORT_MODE = mode_q[ppp_pkg::MODE_SEL_LO +: ppp_pkg::MODE_SEL_W];
    assign std_mode = (O_PORT_MODE == ppp_pkg::PM_STANDARD);
    assign O_FLOPPY_ROUTED = floppy;

    // The printer control pins belong to this logic only in standard mode without floppy routing.
    assign pins_owned = ~floppy & std_mode;

    // In ECP/EPP the mode-specific logic owns the control pins, so release them.
    always_comb
    begin
        O_PRINTER_SELECT_OUT_N = ~ctl_q[ppp_pkg::CTL_SELECT];
        O_PRINTER_INITIALISE_N = ctl_q[ppp_pkg::CTL_INIT];
        O_AUTO_LINE_FEED_N = ~ctl_q[ppp_pkg::CTL_AUTOFD];
        O_DATA_LATCH_PULSE_N = ~ctl_q[ppp_pkg::CTL_STROBE];
        O_PRINTER_SELECT_OUT_OE = pins_owned;
        O_PRINTER_INITIALISE_OE = pins_owned;
        O_AUTO_LINE_FEED_OE = pins_owned;
        O_DATA_LATCH_PULSE_OE = pins_owned;
        // Direction bit set turns the data pins to inputs for the far side.
        O_PORT_DATA = dat_q;
        O_PORT_DATA_OE = ~floppy & ~ctl_q[ppp_pkg::CTL_DIR];
    end
endmodule

// [pkg/ppp_pkg.sv]
package ppp_pkg;
    // Register byte addresses on the AHB-Lite slave.
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
    localparam int ADDR_W = 8;
    // Printer control register fields.
    localparam int CTL_STROBE = 0;
    localparam int CTL_AUTOFD = 1;
    localparam int CTL_INIT = 2;
    localparam int CTL_SELECT = 3;
    localparam int CTL_DIR = 5;
    // Printer status register fields.
    localparam int STS_FAULT = 3;
    localparam int STS_ONLINE = 4;
    localparam int STS_PAPER = 5;
    localparam int STS_ACK = 6;
    localparam int STS_BUSY = 7;
    // Mode register fields.
    localparam int MODE_FLOPPY = 0;
    localparam int MODE_SEL_LO = 1;
    localparam int MODE_SEL_W = 2;
    // Interrupt event bits.
    localparam int EV_ACK = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_PAPER = 2;
    localparam int EV_W = 3;
    // Reset values.
    localparam logic [7:0] CTL_RESET = 8'h04;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] MODE_RESET = 3'h0;
    // Port operating modes.
    localparam logic [1:0] PM_STANDARD = 2'h0;
    localparam logic [1:0] PM_EPP = 2'h1;
    localparam logic [1:0] PM_ECP = 2'h2;
    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
endpackage

// [dv/ppp_port_props.sv]
`timescale 1ns/100ps
// Shadows control and data from bus writes and holds the pins to them.
module ppp_port_props (
    input wire logic I_REF_CLK, I_RST, I_CE, I_HSEL, I_HWRITE, I_HREADY, // Clock, reset, bus.
    input wire logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, // Bus address and data.
    input wire logic [1:0] I_HTRANS, // Transfer type.
    input wire logic O_PRINTER_SELECT_OUT_N, O_PRINTER_INITIALISE_N, O_AUTO_LINE_FEED_N, // Pins.
    input wire logic O_DATA_LATCH_PULSE_N, O_PORT_DATA_OE, O_FLOPPY_ROUTED, // Pins.
    input wire logic [7:0] O_PORT_DATA, // Data pins.
    input wire logic I_PRINTER_BUSY, I_PRINTER_ONLINE // Status pins.
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    ////////////////////////////////////////
    logic take, rd_sts, wp_q, wp_d;
    logic [7:0] wa_q, wa_d, ctl_q, ctl_d, dat_q, dat_d;
    assign take = I_HSEL & I_HREADY & I_HTRANS[1] & I_CE;
    assign rd_sts = take & !I_HWRITE & (I_HADDR[7:0] == ppp_pkg::ADDR_STATUS);
    // A write lands at the edge that ends its data phase.
    always_comb
    begin
        wp_d = take & I_HWRITE;
        wa_d = I_HADDR[7:0];
        ctl_d = (wp_q && wa_q == ppp_pkg::ADDR_CONTROL) ? I_HWDATA[7:0] : ctl_q;
        dat_d = (wp_q && wa_q == ppp_pkg::ADDR_DATA) ? I_HWDATA[7:0] : dat_q;
    end
    // Shadow registers.
    always_ff @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
            {wp_q, wa_q, ctl_q, dat_q} <= {1'b0, 8'h00, ppp_pkg::CTL_RESET, ppp_pkg::DATA_RESET};
        else
            {wp_q, wa_q, ctl_q, dat_q} <= {wp_d, wa_d, ctl_d, dat_d};
    end
    ////////////////////////////////////////
    // A status bit is judged only once its pin has held still through the sync flops.
    property p_sts(logic pin, int b, logic inv);
        $stable(pin) [*4] ##0 rd_sts |=> O_HRDATA[b] == ($past(pin) ^ inv);
    endproperty
    a_select_pin: assert property (O_PRINTER_SELECT_OUT_N == !ctl_q[3]) else $error("select pin");
    a_init_pin: assert property (O_PRINTER_INITIALISE_N == ctl_q[2]) else $error("init pin");
    a_feed_pin: assert property (O_AUTO_LINE_FEED_N == !ctl_q[1]) else $error("feed pin");
    a_strobe_pin: assert property (O_DATA_LATCH_PULSE_N == !ctl_q[0]) else $error("strobe pin");
    a_busy_bit: assert property (p_sts(I_PRINTER_BUSY, 7, 1'b1)) else $error("busy bit");
    a_online_bit: assert property (p_sts(I_PRINTER_ONLINE, 4, 1'b0)) else $error("online bit");
    a_floppy_yields: assert property (O_FLOPPY_ROUTED |-> !O_PORT_DATA_OE) else $error("no yield");
    a_data_pins: assert property (O_PORT_DATA == dat_q) else $error("data pins");
    c_busy_read: cover property (rd_sts && I_PRINTER_BUSY);
    c_floppy: cover property (O_FLOPPY_ROUTED);
    c_strobe: cover property (!O_DATA_LATCH_PULSE_N);
endmodule

// [dv/ppp_printer_model.sv]
`timescale 1ns/100ps
// Printer: takes a byte on the strobe, stays busy, then acknowledges.
module ppp_printer_model (
    input wire logic I_REF_CLK, O_DATA_LATCH_PULSE_N, O_DATA_LATCH_PULSE_OE, // Clock, strobe.
    input wire logic paper_empty, powered, fault, // Printer state.
    input wire logic [7:0] I_PORT_DATA, hold, // Data wire, busy time.
    output logic I_PRINTER_BUSY = 1'b0, I_PRINTER_ACKNOWLEDGE_N = 1'b1, // Handshake.
    output logic I_PAPER_OUT, I_PRINTER_ONLINE, I_PRINTER_FAULT_N, // Levels.
    output logic [7:0] got = 8'h00 // Last byte taken.
);
    logic [7:0] cnt = 8'h00;
    // A released strobe floats high on its pull-up, so nothing is taken then.
    always @(posedge I_REF_CLK)
    begin
        I_PRINTER_ACKNOWLEDGE_N <= 1'b1;
        if (!I_PRINTER_BUSY && O_DATA_LATCH_PULSE_OE && !O_DATA_LATCH_PULSE_N)
        begin
            I_PRINTER_BUSY <= 1'b1;
            got <= I_PORT_DATA;
            cnt <= hold;
        end
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        else if (I_PRINTER_BUSY)
        begin
            I_PRINTER_BUSY <= 1'b0;
            I_PRINTER_ACKNOWLEDGE_N <= 1'b0;
        end
    end
    // Level lines follow the printer's state.
    assign I_PAPER_OUT = paper_empty;
    assign I_PRINTER_ONLINE = powered;
    assign I_PRINTER_FAULT_N = !fault;
endmodule

// [dv/ppp_port_tb_top.sv]
`timescale 1ns/100ps
// Bench: bus tasks, a printer model on the pins, one task per scenario.
module ppp_port_tb_top;
    logic I_REF_CLK = 1'b0, I_RST = 1'b1, I_CE = 1'b1, I_HSEL = 1'b1, I_HWRITE = 1'b0, I_HREADY;
    logic [31:0] I_HADDR = 32'h00000000, I_HWDATA = 32'h00000000, O_HRDATA, rd;
    logic [1:0] I_HTRANS = 2'h0, O_PORT_MODE;
    logic [2:0] I_HSIZE = 3'h2;
    logic [7:0] I_PORT_DATA, O_PORT_DATA, got, pd_ext = 8'h00, hold = 8'h02;
    logic paper_empty = 1'b0, powered = 1'b1, fault = 1'b0, O_HREADYOUT, O_HRESP, O_IRQ, O_PORT_DATA_OE;
    logic O_FLOPPY_ROUTED, O_PRINTER_SELECT_OUT_N, O_PRINTER_SELECT_OUT_OE, O_PRINTER_INITIALISE_N;
    logic O_PRINTER_INITIALISE_OE, O_AUTO_LINE_FEED_N, O_AUTO_LINE_FEED_OE, O_DATA_LATCH_PULSE_N;
    logic O_DATA_LATCH_PULSE_OE, I_PRINTER_BUSY, I_PRINTER_ACKNOWLEDGE_N, I_PAPER_OUT, I_PRINTER_ONLINE;
    logic I_PRINTER_FAULT_N;
    int bad_count = 0, n_tests = 0;
    // One slave, so its ready is the bus ready; the data wire resolves from the enable.
    assign I_HREADY = O_HREADYOUT;
    assign I_PORT_DATA = O_PORT_DATA_OE ? O_PORT_DATA : pd_ext;
    ppp_port u_ppp_port (.*);
    ppp_printer_model u_ppp_printer_model (.*);
    // 125 MHz clock.
    initial
    begin
        forever #4 I_REF_CLK = ~I_REF_CLK;
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One single transfer; read data are taken at the edge ending the data phase.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_REF_CLK);
        I_HADDR <= {24'h000000, a};
        I_HWRITE <= wr;
        I_HTRANS <= ppp_pkg::HTRANS_NONSEQ;
        do @(posedge I_REF_CLK); while (I_HREADY !== 1'b1);
        I_HTRANS <= 2'h0;
        I_HWDATA <= d;
        do @(posedge I_REF_CLK); while (I_HREADY !== 1'b1);
        rd = O_HRDATA;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge I_REF_CLK);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////
    // Every control code reaches the four pins.
    task automatic t_control();
        bus(1'b0, ppp_pkg::ADDR_CONTROL, 32'h0);
        check(rd, 32'h04, "control reset");
        check({O_HREADYOUT, O_HRESP}, 2'h2, "bus response");
        check({O_PRINTER_SELECT_OUT_OE, O_PRINTER_INITIALISE_OE, O_AUTO_LINE_FEED_OE, O_DATA_LATCH_PULSE_OE,
            O_PORT_DATA_OE}, 5'h1F, "owned pins");
        for (int v = 0; v < 16; v++)
        begin
            bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'(v));
            step(0);
            check({O_PRINTER_SELECT_OUT_N, O_PRINTER_INITIALISE_N, O_AUTO_LINE_FEED_N, O_DATA_LATCH_PULSE_N},
                {~v[3], v[2], ~v[1], ~v[0]}, "pins");
        end
        bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'h04);
    endtask
    // Every mix of paper, power and fault shows in the status bits.
    task automatic t_status();
        for (int s = 0; s < 8; s++)
        begin
            @(posedge I_REF_CLK);
            {paper_empty, powered, fault} <= 3'(s);
            step(5);
            bus(1'b0, ppp_pkg::ADDR_STATUS, 32'h0);
            check(rd[7:3], {2'h3, s[2], s[1], ~s[0]}, "status");
        end
    endtask
    // A byte is printed; busy is read mid-way, the acknowledge raises and then is masked.
    task automatic t_print();
        hold <= 8'h14;
        bus(1'b1, ppp_pkg::ADDR_IRQ_CLR, 32'h7);
        bus(1'b1, ppp_pkg::ADDR_IRQ_EN, 32'h1);
        bus(1'b1, ppp_pkg::ADDR_DATA, 32'hA5);
        bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'h05);
        bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'h04);
        step(3);
        bus(1'b0, ppp_pkg::ADDR_STATUS, 32'h0);
        check(rd[7], 1'b0, "busy bit");
        check(got, 8'hA5, "byte taken");
        step(30);
        check(O_IRQ, 1'b1, "irq");
        bus(1'b1, ppp_pkg::ADDR_IRQ_CLR, 32'h1);
        bus(1'b1, ppp_pkg::ADDR_IRQ_EN, 32'h0);
        bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'h05);
        bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'h04);
        step(40);
        check(O_IRQ, 1'b0, "masked irq");
        bus(1'b0, ppp_pkg::ADDR_IRQ_STAT, 32'h0);
        check(rd[0], 1'b1, "sticky event");
    endtask
    // Floppy mode releases the pins and ECP/EPP the strobe pin; read-back and an unmapped read.
    task automatic t_modes();
        bus(1'b1, ppp_pkg::ADDR_MODE, 32'h1);
        step(0);
        check({O_FLOPPY_ROUTED, O_PRINTER_SELECT_OUT_OE, O_PORT_DATA_OE}, 3'h4, "floppy");
        check({O_PRINTER_INITIALISE_OE, O_AUTO_LINE_FEED_OE, O_DATA_LATCH_PULSE_OE}, 3'h0, "floppy oe");
        for (int m = 1; m < 3; m++)
        begin
            bus(1'b1, ppp_pkg::ADDR_MODE, 32'(m * 2));
            step(0);
            check({O_PORT_MODE, O_DATA_LATCH_PULSE_OE}, {2'(m), 1'b0}, "mode");
        end
        bus(1'b1, ppp_pkg::ADDR_MODE, 32'h0);
        bus(1'b1, ppp_pkg::ADDR_CONTROL, 32'h24);
        pd_ext <= 8'h3C;
        step(4);
        bus(1'b0, ppp_pkg::ADDR_DATA, 32'h0);
        check(rd, 32'h3C, "read back");
        bus(1'b0, 8'h1C, 32'h0);
        check(rd, 32'h0, "unmapped");
    endtask
    // Main sequence.
    initial
    begin
        repeat (3) @(posedge I_REF_CLK);
        I_RST <= 1'b0;
        t_control();
        t_status();
        t_print();
        t_modes();
        tally_and_finish();
    end
    // The run needs about 260 cycles; far beyond that it has hung.
    initial
    begin
        #50us;
        bad_count++;
        tally_and_finish();
    end
endmodule
bind ppp_port ppp_port_props u_ppp_port_props (.*);
